/* File: crf_core.sv */
// CPU architectural registers, flags, low-power and break entry
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module crf_core
  import crf_pkg::*;
#(
  parameter int STAB_COUNT = STAB_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire crf_pkg::crf_alu_req_t alu_req,
  input wire crf_pkg::crf_sp_req_t sp_req,
  input wire crf_pkg::crf_pc_req_t pc_req,
  input wire logic [7:0] vec_byte,
  input wire logic push_upper_index_instr,
  input wire logic pull_upper_index_instr,
  input wire logic [7:0] pull_data,
  input wire logic clear_mask_instr,
  input wire logic set_mask_instr,
  input wire logic irq_stacked,
  input wire logic return_from_irq_instr,
  input wire logic [7:0] stacked_flags,
  input wire logic wait_instr,
  input wire logic stop_instr,
  input wire logic irq_request,
  input wire logic ext_irq,
  input wire logic break_request,
  input wire logic monitor_mode,
  input wire logic instr_last_cycle,
  output logic irq_accept,
  output logic [7:0] accumulator,
  output logic [15:0] index_pair,
  output logic [15:0] stack_pointer,
  output logic [15:0] program_counter,
  output logic [7:0] condition_flags,
  output logic [15:0] vector_addr,
  output logic [7:0] instr_reg,
  output logic cpu_clk_run,
  output logic break_active
);
  import crf_pkg::*;

  typedef enum {PM_RUN, PM_WAIT, PM_STOP, PM_STAB} crf_pmode_t;

  logic [7:0] acc_reg, acc_next;
  logic [7:0] idx_hi_reg, idx_lo_reg;
  logic [15:0] sp_reg, pc_reg;
  logic [7:0] flags_reg, flags_next;
  crf_pmode_t pmode_reg;
  logic [31:0] stab_cnt_reg;
  logic brk_pending_reg, brk_active_reg;
  logic [7:0] ir_reg;
  logic [15:0] vec_reg;
  logic ext_s1_reg, ext_s2_reg, brk_s1_reg, brk_s2_reg;
  logic [8:0] sum;
  logic [4:0] half;
  logic cin;
  logic [7:0] res;
  logic go;
  logic brk_start;

  assign go = clk_en && (pmode_reg == PM_RUN);

  // External pin and break request are asynchronous to this clock
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      brk_s1_reg <= 1'b0;
      brk_s2_reg <= 1'b0;
    end else if (clk_en) begin
      ext_s1_reg <= ext_irq;
      ext_s2_reg <= ext_s1_reg;
      brk_s1_reg <= break_request;
      brk_s2_reg <= brk_s1_reg;
    end
  end

  // ALU result and flag arithmetic
  always_comb begin
    cin = (alu_req.op == ALU_ADC || alu_req.op == ALU_SBC) ? flags_reg[FLAG_C] : 1'b0;
    sum = 9'h000;
    half = 5'h00;
    res = acc_reg;
    flags_next = flags_reg;
    acc_next = acc_reg;
    case (alu_req.op)
      ALU_ADD, ALU_ADC: begin
        sum = {1'b0, acc_reg} + {1'b0, alu_req.operand} + {8'h00, cin};
        half = {1'b0, acc_reg[3:0]} + {1'b0, alu_req.operand[3:0]} + {4'h0, cin};
        res = sum[7:0];
        flags_next[FLAG_H] = half[4];
        flags_next[FLAG_C] = sum[8];
        flags_next[FLAG_V] = (acc_reg[7] == alu_req.operand[7]) && (res[7] != acc_reg[7]);
      end
      ALU_SUB, ALU_SBC: begin
        sum = {1'b0, acc_reg} - {1'b0, alu_req.operand} - {8'h00, cin};
        res = sum[7:0];
        flags_next[FLAG_C] = sum[8];
        flags_next[FLAG_V] = (acc_reg[7] != alu_req.operand[7]) && (res[7] != acc_reg[7]);
      end
      ALU_LOGIC, ALU_LOAD: begin
        res = (alu_req.op == ALU_LOAD) ? alu_req.operand : alu_req.logic_result;
        flags_next[FLAG_V] = 1'b0;
      end
      ALU_SHIFT: begin
        res = alu_req.logic_result;
        flags_next[FLAG_C] = alu_req.shift_carry;
        flags_next[FLAG_V] = alu_req.shift_ovf;
      end
      default: res = acc_reg;
    endcase
    if (alu_req.op != ALU_NONE) begin
      flags_next[FLAG_N] = res[7];
      flags_next[FLAG_Z] = (res == 8'h00);
      if (alu_req.write_acc) acc_next = res;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      acc_reg <= 8'h00;
    end else if (go && reg_wr && reg_addr == REG_ACC) begin
      acc_reg <= reg_wdata;
    end else if (go) begin
      acc_reg <= acc_next;
    end
  end

  // Index pair; upper byte only moves by explicit push/pull or writes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      idx_hi_reg <= 8'h00;
      idx_lo_reg <= 8'h00;
    end else if (go) begin
      if (reg_wr && reg_addr == REG_IDX_HI) idx_hi_reg <= reg_wdata;
      else if (pull_upper_index_instr) idx_hi_reg <= pull_data;
      if (reg_wr && reg_addr == REG_IDX_LO) idx_lo_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sp_reg <= SP_RESET;
    end else if (go) begin
      if (reg_wr && reg_addr == REG_SP_HI) sp_reg[15:8] <= reg_wdata;
      else if (reg_wr && reg_addr == REG_SP_LO) sp_reg[7:0] <= reg_wdata;
      else if (sp_req.reset_low) sp_reg[7:0] <= SP_LOW_ONES;
      else if (sp_req.load) sp_reg <= sp_req.value;
      else if (sp_req.push || push_upper_index_instr) sp_reg <= sp_reg - 16'h0001;
      else if (sp_req.pull || pull_upper_index_instr) sp_reg <= sp_reg + 16'h0001;
    end
  end

  // Vector high byte then low byte; reset vector fetched after release
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      vec_reg <= VEC_RESET_HI;
      pc_reg <= 16'h0000;
    end else if (clk_en) begin
      // Gated by run mode so a frozen core never moves the vector pointer
      if (go && brk_start) begin
        vec_reg <= monitor_mode ? VEC_BREAK_MON_HI : VEC_BREAK_HI;
      end else if (go && irq_stacked) begin
        vec_reg <= {vec_byte, 8'h00};
      end else if (go && pc_req.load_vec_hi) begin
        // Low vector byte sits one address above the high byte
        vec_reg <= vec_reg + 16'h0001;
      end
      if (go) begin
        if (reg_wr && reg_addr == REG_PC_HI) pc_reg[15:8] <= reg_wdata;
        else if (reg_wr && reg_addr == REG_PC_LO) pc_reg[7:0] <= reg_wdata;
        else if (pc_req.load_vec_hi) pc_reg[15:8] <= vec_byte;
        else if (pc_req.load_vec_lo) pc_reg[7:0] <= vec_byte;
        else if (pc_req.load) pc_reg <= pc_req.value;
        else if (pc_req.fetch) pc_reg <= pc_reg + 16'h0001;
      end
    end
  end

  // Condition flags; mask ordering relative to stacking and vectors
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flags_reg <= FLAGS_RESET;
    end else if (clk_en) begin
      if (pmode_reg == PM_RUN) begin
        if (reg_wr && reg_addr == REG_FLAGS) begin
          flags_reg <= reg_wdata | FLAGS_ONES;
        end else if (return_from_irq_instr) begin
          flags_reg <= stacked_flags | FLAGS_ONES;
        end else if (wait_instr || stop_instr) begin
          flags_reg <= flags_next & ~(8'h01 << FLAG_I);
        end else if (clear_mask_instr) begin
          flags_reg <= flags_next & ~(8'h01 << FLAG_I);
        end else if (irq_stacked || set_mask_instr || brk_start) begin
          flags_reg <= flags_next | (8'h01 << FLAG_I);
        end else begin
          flags_reg <= flags_next | FLAGS_ONES;
        end
      end
    end
  end

  assign irq_accept = irq_request && !flags_reg[FLAG_I] && pmode_reg == PM_RUN;

  // Low-power modes; interrupts leave the mask clear, reset sets it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pmode_reg <= PM_RUN;
      stab_cnt_reg <= 32'h0;
    end else if (clk_en) begin
      case (pmode_reg)
        PM_RUN: begin
          if (wait_instr) pmode_reg <= PM_WAIT;
          else if (stop_instr) pmode_reg <= PM_STOP;
        end
        PM_WAIT: if (irq_request || ext_s2_reg) pmode_reg <= PM_RUN;
        PM_STOP: begin
          if (ext_s2_reg) begin
            pmode_reg <= PM_STAB;
            stab_cnt_reg <= 32'h0;
          end
        end
        PM_STAB: begin
          // Clock held until the oscillator is trusted
          if (stab_cnt_reg >= 32'(STAB_COUNT - 1)) pmode_reg <= PM_RUN;
          else stab_cnt_reg <= stab_cnt_reg + 32'h1;
        end
        default: pmode_reg <= PM_RUN;
      endcase
    end
  end

  assign brk_start = brk_pending_reg && instr_last_cycle && !brk_active_reg;

  // Break starts at an instruction boundary; a synchronised match is held pending until a later last cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      brk_pending_reg <= 1'b0;
      brk_active_reg <= 1'b0;
      ir_reg <= 8'h00;
    end else if (go) begin
      if (brk_start) begin
        brk_pending_reg <= 1'b0;
        brk_active_reg <= 1'b1;
        ir_reg <= SWI_OPCODE;
      end else if (brk_s2_reg && !brk_active_reg) begin
        brk_pending_reg <= 1'b1;
      end
      if (brk_active_reg && return_from_irq_instr && !brk_s2_reg) begin
        brk_active_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      case (reg_addr)
        REG_ACC: reg_rdata <= acc_reg;
        REG_IDX_HI: reg_rdata <= idx_hi_reg;
        REG_IDX_LO: reg_rdata <= idx_lo_reg;
        REG_SP_HI: reg_rdata <= sp_reg[15:8];
        REG_SP_LO: reg_rdata <= sp_reg[7:0];
        REG_PC_HI: reg_rdata <= pc_reg[15:8];
        REG_PC_LO: reg_rdata <= pc_reg[7:0];
        REG_FLAGS: reg_rdata <= flags_reg | FLAGS_ONES;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  assign accumulator = acc_reg;
  assign index_pair = {idx_hi_reg, idx_lo_reg};
  assign stack_pointer = sp_reg;
  assign program_counter = pc_reg;
  assign condition_flags = flags_reg | FLAGS_ONES;
  assign vector_addr = vec_reg;
  assign instr_reg = ir_reg;
  assign cpu_clk_run = (pmode_reg == PM_RUN);
  assign break_active = brk_active_reg;

  chk_sp_reset: assert property (@(posedge clock) sys_rst |=> sp_reg == SP_RESET)
    else $error("stack pointer not reset");
  chk_sp_rsp_low: assert property (@(posedge clock) disable iff (sys_rst)
    go && sp_req.reset_low && !reg_wr |=> sp_reg[7:0] == SP_LOW_ONES
      && sp_reg[15:8] == $past(sp_reg[15:8]))
    else $error("reset-stack wrong");
  chk_sp_push_dec: assert property (@(posedge clock) disable iff (sys_rst)
    go && sp_req.push && !sp_req.reset_low && !sp_req.load && !reg_wr
      |=> sp_reg == $past(sp_reg) - 16'h0001)
    else $error("push did not decrement");
  chk_flags_ones: assert property (@(posedge clock) disable iff (sys_rst)
    flags_reg[6:5] == 2'b11)
    else $error("flag ones lost");
  chk_mask_reset: assert property (@(posedge clock) sys_rst |=> flags_reg[FLAG_I])
    else $error("mask clear after reset");
  chk_irq_blocked: assert property (@(posedge clock) flags_reg[FLAG_I] |-> !irq_accept)
    else $error("masked request accepted");
  chk_wait_mask: assert property (@(posedge clock) disable iff (sys_rst)
    go && wait_instr && !reg_wr && !return_from_irq_instr
      |=> !flags_reg[FLAG_I] && !cpu_clk_run)
    else $error("wait entry wrong");
  chk_zero_flag: assert property (@(posedge clock) disable iff (sys_rst)
    go && alu_req.op == ALU_LOAD && !reg_wr && !return_from_irq_instr
      |=> flags_reg[FLAG_Z] == ($past(alu_req.operand) == 8'h00))
    else $error("zero flag wrong");
  chk_break_swi: assert property (@(posedge clock) disable iff (sys_rst)
    go && brk_start |=> ir_reg == SWI_OPCODE && brk_active_reg)
    else $error("break entry wrong");
  chk_stab_hold: assert property (@(posedge clock) disable iff (sys_rst)
    pmode_reg == PM_STOP && clk_en && ext_s2_reg |=> !cpu_clk_run [*2])
    else $error("clock restarted early");
  chk_sp_pull_inc: assert property (@(posedge clock) disable iff (sys_rst)
    go && sp_req.pull && !sp_req.push && !push_upper_index_instr && !sp_req.reset_low
      && !sp_req.load && !reg_wr |=> sp_reg == $past(sp_reg) + 16'h0001)
    else $error("pull did not increment");
  chk_pc_fetch_inc: assert property (@(posedge clock) disable iff (sys_rst)
    go && pc_req.fetch && !pc_req.load && !pc_req.load_vec_hi && !pc_req.load_vec_lo
      && !reg_wr |=> pc_reg == $past(pc_reg) + 16'h0001)
    else $error("fetch did not advance");
  chk_vec_reset: assert property (@(posedge clock)
    sys_rst |=> vec_reg == VEC_RESET_HI)
    else $error("vector pointer not reset");
  chk_irq_mask_set: assert property (@(posedge clock) disable iff (sys_rst)
    go && irq_stacked && !reg_wr && !return_from_irq_instr && !wait_instr && !stop_instr
      && !clear_mask_instr |=> flags_reg[FLAG_I])
    else $error("mask not set on entry");
  chk_upper_idx_hold: assert property (@(posedge clock) disable iff (sys_rst)
    go && irq_stacked && !pull_upper_index_instr && !reg_wr
      |=> idx_hi_reg == $past(idx_hi_reg))
    else $error("upper index moved on entry");
  chk_rti_restore: assert property (@(posedge clock) disable iff (sys_rst)
    go && return_from_irq_instr && !reg_wr
      |=> flags_reg == ($past(stacked_flags) | FLAGS_ONES))
    else $error("return did not restore flags");
  chk_stop_mask: assert property (@(posedge clock) disable iff (sys_rst)
    go && stop_instr && !wait_instr && !reg_wr && !return_from_irq_instr
      |=> !flags_reg[FLAG_I] && !cpu_clk_run)
    else $error("stop entry wrong");
  chk_break_exit: assert property (@(posedge clock) disable iff (sys_rst)
    go && brk_active_reg && return_from_irq_instr && !brk_s2_reg |=> !brk_active_reg)
    else $error("break did not end");
  cov_vec_fetch: cover property (@(posedge clock) go && pc_req.load_vec_lo);
  cov_break: cover property (@(posedge clock) brk_start);
  cov_wait_exit: cover property (@(posedge clock) pmode_reg == PM_WAIT ##1 pmode_reg == PM_RUN);
  cov_stop_exit: cover property (@(posedge clock) pmode_reg == PM_STAB ##1 pmode_reg == PM_RUN);
  cov_irq: cover property (@(posedge clock) irq_accept);
endmodule : crf_core

/* File: crf_pkg.sv */
// Shared constants and carriers for the CPU register and flag core
package crf_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [7:0] SP_LOW_ONES = 8'hff;
  localparam logic [15:0] VEC_RESET_HI = 16'hfffe;
  localparam logic [15:0] VEC_BREAK_HI = 16'hfffc;
  localparam logic [15:0] VEC_BREAK_MON_HI = 16'hfefc;
  localparam logic [7:0] SWI_OPCODE = 8'h83;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I = 3;
  localparam int FLAG_H = 4;
  localparam int FLAG_V = 7;
  localparam logic [7:0] FLAGS_ONES = 8'h60;
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_IDX_HI = 3'h1;
  localparam logic [2:0] REG_IDX_LO = 3'h2;
  localparam logic [2:0] REG_SP_HI = 3'h3;
  localparam logic [2:0] REG_SP_LO = 3'h4;
  localparam logic [2:0] REG_PC_HI = 3'h5;
  localparam logic [2:0] REG_PC_LO = 3'h6;
  localparam logic [2:0] REG_FLAGS = 3'h7;
  localparam int STAB_NS = 40960;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STAB_CYCLES = (STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ALU_NONE, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_LOGIC, ALU_SHIFT, ALU_LOAD
  } crf_alu_op_t;

  typedef struct packed {
    crf_alu_op_t op;
    logic [7:0] operand;
    logic [7:0] logic_result;
    logic shift_carry;
    logic shift_ovf;
    logic write_acc;
  } crf_alu_req_t;

  typedef struct packed {
    logic push;
    logic pull;
    logic reset_low;
    logic load;
    logic [15:0] value;
  } crf_sp_req_t;

  typedef struct packed {
    logic fetch;
    logic load;
    logic load_vec_hi;
    logic load_vec_lo;
    logic [15:0] value;
  } crf_pc_req_t;
endpackage : crf_pkg

/* File: crf_vec_mem.sv */
// Vector memory model standing on the far side of the core
`timescale 1ns/1ps
module crf_vec_mem (
  input wire logic [15:0] vector_addr,
  output logic [7:0] vec_byte
);
  // Arbitrary but address-dependent contents, so a wrong vector fetch shows up
  assign vec_byte = vector_addr[7:0] ^ 8'h5a;
endmodule : crf_vec_mem

/* File: tb_cpu_register_flag_core.sv */
// Self-checking bench for the CPU register and flag core
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_cpu_register_flag_core;
  import crf_pkg::*;
  logic clock, sys_rst, clk_en, reg_wr, reg_rd, push_upper_index_instr, pull_upper_index_instr;
  logic clear_mask_instr, set_mask_instr, irq_stacked, return_from_irq_instr, wait_instr;
  logic stop_instr, irq_request, ext_irq, break_request, monitor_mode, instr_last_cycle;
  logic irq_accept, cpu_clk_run, break_active;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, vec_byte, pull_data, stacked_flags, accumulator;
  logic [7:0] condition_flags, instr_reg, m_acc, m_flags, a, b;
  logic [15:0] index_pair, stack_pointer, program_counter, vector_addr, m_sp;
  crf_alu_req_t alu_req;
  crf_sp_req_t sp_req;
  crf_pc_req_t pc_req;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] seed = 32'd75859;
  logic [8:0] r;
  logic [7:0] lr;
  logic ci;
  crf_alu_op_t op;

  crf_core #(.STAB_COUNT(4)) i_crf_core (.clock, .sys_rst, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .alu_req, .sp_req, .pc_req, .vec_byte,
    .push_upper_index_instr, .pull_upper_index_instr, .pull_data, .clear_mask_instr,
    .set_mask_instr, .irq_stacked, .return_from_irq_instr, .stacked_flags, .wait_instr,
    .stop_instr, .irq_request, .ext_irq, .break_request, .monitor_mode, .instr_last_cycle,
    .irq_accept, .accumulator, .index_pair, .stack_pointer, .program_counter,
    .condition_flags, .vector_addr, .instr_reg, .cpu_clk_run, .break_active);
  crf_vec_mem i_crf_vec_mem (.vector_addr, .vec_byte);

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd

  task automatic report_and_stop();
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge clock) begin reg_wr <= 1'b1; reg_addr <= ad; reg_wdata <= d; end
    @(posedge clock) reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [2:0] ad, input logic [7:0] e);
    @(posedge clock) begin reg_rd <= 1'b1; reg_addr <= ad; end
    @(posedge clock) reg_rd <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
  endtask : rd

  // Bounded wait on the run flag; a hang counts as a mismatch
  task automatic wait_run(input logic v, input int lim);
    int n;
    n = 0;
    while (cpu_clk_run !== v && n < lim) begin @(posedge clock); #1; n++; end
    `CHK("cpu_clk_run", v, cpu_clk_run)
  endtask : wait_run

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles > 5000) begin errors++; report_and_stop(); end
  end

  initial begin
    {reg_wr, reg_rd, push_upper_index_instr, pull_upper_index_instr, clear_mask_instr} = '0;
    {set_mask_instr, irq_stacked, return_from_irq_instr, wait_instr, stop_instr} = '0;
    {irq_request, ext_irq, break_request, monitor_mode, instr_last_cycle} = '0;
    {reg_addr, reg_wdata, pull_data, stacked_flags} = '0;
    alu_req = '0; sp_req = '0; pc_req = '0;
    clk_en = 1'b1; sys_rst = 1'b1;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock); #1;
    `CHK("stack_pointer", SP_RESET, stack_pointer)
    `CHK("condition_flags", FLAGS_RESET, condition_flags)
    `CHK("vector_addr", VEC_RESET_HI, vector_addr)
    // Reset vector: high byte, then low byte from the next address
    lr = VEC_RESET_HI[7:0];
    @(posedge clock) pc_req.load_vec_hi <= 1'b1;
    @(posedge clock) begin
      pc_req.load_vec_hi <= 1'b0;
      pc_req.load_vec_lo <= 1'b1;
    end
    @(posedge clock) pc_req.load_vec_lo <= 1'b0;
    #1 `CHK("program_counter", {lr ^ 8'h5a, (lr + 8'h01) ^ 8'h5a}, program_counter)
    m_flags = FLAGS_RESET;
    // Masked request must not be accepted until the clear instruction
    @(posedge clock) irq_request <= 1'b1;
    @(posedge clock); #1 `CHK("irq_accept", 1'b0, irq_accept)
    wr(REG_FLAGS, 8'h08);
    rd(REG_FLAGS, FLAGS_RESET);
    @(posedge clock) clear_mask_instr <= 1'b1;
    @(posedge clock) clear_mask_instr <= 1'b0;
    #1 `CHK("irq_accept", 1'b1, irq_accept)
    m_flags[FLAG_I] = 1'b0;
    for (int k = 0; k < 14; k++) begin
      a = rnd();
      b = rnd();
      lr = rnd();
      op = crf_alu_op_t'(k % 7 + 1);
      wr(REG_ACC, a);
      @(posedge clock) begin
        alu_req.op <= op;
        alu_req.operand <= b;
        alu_req.logic_result <= lr;
        alu_req.shift_carry <= a[0];
        alu_req.shift_ovf <= b[0];
        alu_req.write_acc <= 1'b1;
      end
      @(posedge clock) alu_req <= '0;
      #1 ci = (op == ALU_ADC || op == ALU_SBC) ? m_flags[FLAG_C] : 1'b0;
      case (op)
        ALU_ADD, ALU_ADC: begin
          r = {1'b0, a} + {1'b0, b} + {8'h00, ci};
          m_flags[FLAG_H] = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci}) > 5'h0f;
          m_flags[FLAG_V] = (a[7] == b[7]) && (r[7] != a[7]);
          m_flags[FLAG_C] = r[8];
        end
        ALU_SUB, ALU_SBC: begin
          r = {1'b0, a} - {1'b0, b} - {8'h00, ci};
          m_flags[FLAG_V] = (a[7] != b[7]) && (r[7] != a[7]);
          m_flags[FLAG_C] = r[8];
        end
        ALU_SHIFT: begin
          r = {1'b0, lr};
          m_flags[FLAG_V] = b[0];
          m_flags[FLAG_C] = a[0];
        end
        default: begin
          r = {1'b0, (op == ALU_LOAD) ? b : lr};
          m_flags[FLAG_V] = 1'b0;
        end
      endcase
      m_acc = r[7:0];
      m_flags[FLAG_Z] = (m_acc == 8'h00);
      m_flags[FLAG_N] = m_acc[7];
      `CHK("accumulator", m_acc, accumulator)
      `CHK("condition_flags", m_flags, condition_flags)
      wr(REG_IDX_HI, b); wr(REG_IDX_LO, a);
      `CHK("index_pair", {b, a}, index_pair)
    end
    // Entry sets the mask and leaves the upper index byte alone
    @(posedge clock) irq_stacked <= 1'b1;
    @(posedge clock) irq_stacked <= 1'b0;
    #1 `CHK("mask", 1'b1, condition_flags[FLAG_I])
    `CHK("index_pair", {b, a}, index_pair)
    `CHK("irq_accept", 1'b0, irq_accept)
    wr(REG_SP_HI, 8'h12); wr(REG_SP_LO, 8'h34);
    m_sp = 16'h1234;
    @(posedge clock) sp_req.push <= 1'b1;
    repeat (3) @(posedge clock);
    sp_req.push <= 1'b0;
    sp_req.pull <= 1'b1;
    @(posedge clock) sp_req.pull <= 1'b0;
    #1 `CHK("stack_pointer", m_sp - 16'd2, stack_pointer)
    @(posedge clock) sp_req.reset_low <= 1'b1;
    @(posedge clock) sp_req.reset_low <= 1'b0;
    #1 `CHK("stack_pointer", {m_sp[15:8], SP_LOW_ONES}, stack_pointer)
    b = rnd();
    @(posedge clock) begin
      pull_upper_index_instr <= 1'b1;
      pull_data <= b;
    end
    @(posedge clock) pull_upper_index_instr <= 1'b0;
    #1 `CHK("index_pair", {b, a}, index_pair)
    `CHK("stack_pointer", {m_sp[15:8], SP_LOW_ONES} + 16'h0001, stack_pointer)
    @(posedge clock) push_upper_index_instr <= 1'b1;
    @(posedge clock) push_upper_index_instr <= 1'b0;
    #1 `CHK("stack_pointer", {m_sp[15:8], SP_LOW_ONES}, stack_pointer)
    wr(REG_PC_HI, 8'h40); wr(REG_PC_LO, 8'hff);
    @(posedge clock) pc_req.fetch <= 1'b1;
    @(posedge clock);
    @(posedge clock) pc_req.fetch <= 1'b0;
    #1 `CHK("program_counter", 16'h4101, program_counter)
    @(posedge clock) begin pc_req.load <= 1'b1; pc_req.value <= 16'hc35a; end
    @(posedge clock) pc_req.load <= 1'b0;
    #1 `CHK("program_counter", 16'hc35a, program_counter)
    // Clock enable low freezes the counter despite a fetch request
    @(posedge clock) clk_en <= 1'b0;
    @(posedge clock) pc_req.fetch <= 1'b1;
    @(posedge clock);
    @(posedge clock) begin
      pc_req.fetch <= 1'b0;
      clk_en <= 1'b1;
    end
    #1 `CHK("program_counter", 16'hc35a, program_counter)
    // Wait entry, interrupt exit keeps mask clear
    @(posedge clock) begin irq_request <= 1'b0; set_mask_instr <= 1'b1; end
    @(posedge clock) begin set_mask_instr <= 1'b0; wait_instr <= 1'b1; end
    @(posedge clock) wait_instr <= 1'b0;
    #1 wait_run(1'b0, 1);
    `CHK("mask", 1'b0, condition_flags[FLAG_I])
    @(posedge clock) irq_request <= 1'b1;
    wait_run(1'b1, 10);
    `CHK("mask", 1'b0, condition_flags[FLAG_I])
    // Wait exit by reset sets the mask again
    @(posedge clock) begin irq_request <= 1'b0; wait_instr <= 1'b1; end
    @(posedge clock) begin wait_instr <= 1'b0; sys_rst <= 1'b1; end
    @(posedge clock) sys_rst <= 1'b0;
    #1 `CHK("condition_flags", FLAGS_RESET, condition_flags)
    // Stop exit needs sync plus stabilisation, so no run in the first four cycles
    @(posedge clock) stop_instr <= 1'b1;
    @(posedge clock) begin stop_instr <= 1'b0; ext_irq <= 1'b1; end
    repeat (4) @(posedge clock);
    #1 `CHK("cpu_clk_run", 1'b0, cpu_clk_run)
    wait_run(1'b1, 20);
    `CHK("mask", 1'b0, condition_flags[FLAG_I])
    for (int m = 0; m < 2; m++) begin
      @(posedge clock) begin
        ext_irq <= 1'b0;
        monitor_mode <= m[0]; instr_last_cycle <= 1'b1; break_request <= 1'b1;
      end
      for (int n = 0; n < 10 && break_active !== 1'b1; n++) begin @(posedge clock); #1; end
      `CHK("break_active", 1'b1, break_active)
      `CHK("instr_reg", SWI_OPCODE, instr_reg)
      `CHK("vector_addr", m ? VEC_BREAK_MON_HI : VEC_BREAK_HI, vector_addr)
      @(posedge clock) break_request <= 1'b0;
      repeat (4) @(posedge clock);
      begin return_from_irq_instr <= 1'b1; stacked_flags <= 8'h08; end
      @(posedge clock) return_from_irq_instr <= 1'b0;
      #1 `CHK("break_active", 1'b0, break_active)
      `CHK("condition_flags", FLAGS_RESET, condition_flags)
    end
    report_and_stop();
  end
endmodule : tb_cpu_register_flag_core
